// File: core/tcfm_params.svh
// constants of the traffic conflict fault monitor
//
// How it works
// - either inhibit input blocks only red failure
// - inhibit active after 550 ms high
// - red input on after 500 ms high
// - green/yellow input on after 500 ms high
// - red, clearance, dual and watchdog faults latch until panel or remote reset
// - no indication beyond 1000/1500 ms trips red failure
// - red failure enabled per channel switch
// - red failure needs enable, no inhibit, common idle
// - green must be followed by 2.7 s yellow
// - clearance per channel, gated by yellow inhibit, enable, common
// - two indications over 500 ms trip dual
// - dual enables per channel plus global green-yellow
// - config compared to stored copy, card led flashes
// - config fault cleared only by 3 s panel hold
// - line dropout faults, power led 2 Hz
// - restore re-runs start-up, latched faults persist
// - start-up interval suspends red, clearance and dual checks, relay closed, 4 Hz
// - start-up ends after 6 s, 5 edges, line good
// - under 5 edges by 10 s latches watchdog fault
// - arrow mode and per-phase arrow switches
// - standard arrow mode channel mapping
// - jumper selects relay common active polarity
`ifndef TCFM_PARAMS_SVH
`define TCFM_PARAMS_SVH
`define TCFM_SYS_CLK_HZ 25000000
`define TCFM_TICK_MS 1
`define TCFM_TICK_CYC (`TCFM_SYS_CLK_HZ / 1000 * `TCFM_TICK_MS)
`define TCFM_IN_ON_MS 500
`define TCFM_INH_ON_MS 550
`define TCFM_RF_A_MS 1000
`define TCFM_RF_B_MS 1500
`define TCFM_CLR_MS 2700
`define TCFM_DUAL_MS 500
`define TCFM_CFG_RST_MS 3000
`define TCFM_ST_MIN_MS 6000
`define TCFM_ST_MAX_MS 10000
`define TCFM_BLINK4_HZ 4
`define TCFM_IN_ON_CNT (`TCFM_IN_ON_MS / `TCFM_TICK_MS)
`define TCFM_INH_ON_CNT (`TCFM_INH_ON_MS / `TCFM_TICK_MS)
`define TCFM_RF_A_CNT (`TCFM_RF_A_MS / `TCFM_TICK_MS)
`define TCFM_RF_B_CNT (`TCFM_RF_B_MS / `TCFM_TICK_MS)
`define TCFM_CLR_CNT (`TCFM_CLR_MS / `TCFM_TICK_MS)
`define TCFM_DUAL_CNT (`TCFM_DUAL_MS / `TCFM_TICK_MS)
`define TCFM_CFG_RST_CNT (`TCFM_CFG_RST_MS / `TCFM_TICK_MS)
`define TCFM_ST_MIN_CNT (`TCFM_ST_MIN_MS / `TCFM_TICK_MS)
`define TCFM_ST_MAX_CNT (`TCFM_ST_MAX_MS / `TCFM_TICK_MS)
`define TCFM_BLINK4_CNT (1000 / (2 * `TCFM_BLINK4_HZ) / `TCFM_TICK_MS)
`define TCFM_WD_EDGES 3'd5
`define TCFM_A_CTRL 8'h00
`define TCFM_A_RF_EN 8'h04
`define TCFM_A_CLR_EN 8'h08
`define TCFM_A_DUAL_EN 8'h0C
`define TCFM_A_YINH 8'h10
`define TCFM_A_STATUS 8'h14
`define TCFM_A_FAULT_CH 8'h18
`define TCFM_C_TYPE 0
`define TCFM_C_GY_DUAL 1
`define TCFM_C_COMPACT 2
`define TCFM_C_POL 3
`define TCFM_C_ARROW 4
`define TCFM_F_RED 0
`define TCFM_F_CLR 1
`define TCFM_F_DUAL 2
`define TCFM_F_CFG 3
`define TCFM_F_WDT 4
`define TCFM_F_PWR 5
`define TCFM_S_STATE 8
`endif

// File: core/tcfm_pkg.sv
// types of the traffic conflict fault monitor
package tcfm_pkg;
  typedef enum logic [1:0] {
    TCFM_ST_START = 2'b00,
    TCFM_ST_RUN = 2'b01,
    TCFM_ST_DROP = 2'b10
  } tcfm_state_e;
  typedef logic [5:0] tcfm_flt_t;
endpackage : tcfm_pkg

// File: core/tcfm_time_if.sv
// timebase carrier: millisecond tick and indicator blink phases
`timescale 1ns/1ps
`default_nettype none
interface tcfm_time_if;
  logic ms_tick;
  logic blink2;
  logic blink4;
  modport src (output ms_tick, output blink2, output blink4);
  modport snk (input ms_tick, input blink2, input blink4);
endinterface : tcfm_time_if
`default_nettype wire

// File: core/tcfm_tick.sv
// timebase: millisecond tick and 4 Hz / 2 Hz blink phases
`timescale 1ns/1ps
`default_nettype none
`include "tcfm_params.svh"
module tcfm_tick #(
  parameter int TICK_DIV = `TCFM_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  tcfm_time_if.src tm
);
  typedef struct packed {
    logic [15:0] div;
    logic [7:0] half;
    logic tick;
    logic b4;
    logic b2;
  } tcfm_tick_s;
  tcfm_tick_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.div == 16'(TICK_DIV - 1)) begin
      next_st.div = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 16'h0001;
    end
    if (st.tick) begin
      if (st.half == 8'(`TCFM_BLINK4_CNT - 1)) begin
        next_st.half = 8'h00;
        next_st.b4 = ~st.b4;
        // 2 Hz halves the 4 Hz phase, so both stay at 50% duty
        if (st.b4) begin
          next_st.b2 = ~st.b2;
        end
      end else begin
        next_st.half = st.half + 8'h01;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tm.ms_tick = st.tick;
  assign tm.blink4 = st.b4;
  assign tm.blink2 = st.b2;
endmodule : tcfm_tick
`default_nettype wire

// File: core/tcfm_qual.sv
// input synchroniser and on-duration qualifier for a group of field inputs
`timescale 1ns/1ps
`default_nettype none
module tcfm_qual #(
  parameter int N = 1,
  parameter int ON_CNT = 500,
  parameter int CW = 10
) (
  input wire logic sys_clk,
  input wire logic srst,
  tcfm_time_if.snk tm,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] qual
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0] q;
  } tcfm_qual_s;
  tcfm_qual_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    for (int i = 0; i < N; i++) begin
      if (!st.s2[i]) begin
        next_st.cnt[i] = '0;
        next_st.q[i] = 1'b0;
      end else if (tm.ms_tick && !st.q[i]) begin
        // short pulses never reach the on count, so the band between stays off
        if (st.cnt[i] >= CW'(ON_CNT - 1)) begin
          next_st.q[i] = 1'b1;
        end else begin
          next_st.cnt[i] = st.cnt[i] + CW'(1);
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign qual = st.q;
endmodule : tcfm_qual
`default_nettype wire

// File: core/tcfm_monitor.sv
// traffic conflict fault monitor: fault checks, latches, start-up and APB registers
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcfm_params.svh"
module tcfm_monitor #(
  parameter int NCH = 18,
  parameter int TICK_DIV = `TCFM_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] red_in,
  input wire logic [NCH-1:0] yel_in,
  input wire logic [NCH-1:0] grn_in,
  input wire logic red_enable,
  input wire logic [1:0] rf_inhibit,
  input wire logic relay_common_sense,
  input wire logic watchdog_in,
  input wire logic line_dropout,
  input wire logic line_ok,
  input wire logic panel_reset,
  input wire logic remote_reset,
  output logic relay_flash,
  output logic power_led,
  output logic card_led,
  output tcfm_pkg::tcfm_flt_t fault_flags
);
  import tcfm_pkg::*;
  localparam int NS = NCH + 4;
  localparam int CFGW = 8 + 4 * NCH;
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic wd_prev;
    logic [2:0] wd_n;
    tcfm_state_e state;
    logic [13:0] tcnt;
    logic [11:0] hold;
    logic pnl_prev;
    logic rem_prev;
    logic [7:0] ctrl;
    logic [NCH-1:0] rf_en;
    logic [NCH-1:0] clr_en;
    logic [NCH-1:0] dual_en;
    logic [NCH-1:0] yinh;
    logic [CFGW-1:0] snap;
    logic snap_ok;
    logic [NS-1:0][10:0] acnt;
    logic [NS-1:0][8:0] dcnt;
    logic [NS-1:0][11:0] ycnt;
    logic [NS-1:0] gseen;
    tcfm_flt_t flt;
    logic [NS-1:0] fch;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic relay;
    logic pwr_led;
    logic card_led;
  } tcfm_mon_s;
  tcfm_mon_s st, n;

  tcfm_time_if tm ();
  logic [1:0] inh_q;
  logic [3*NCH-1:0] fq;
  logic [NCH-1:0] qr, qy, qg;
  logic [NS-1:0] sr, sy, sg, sga, s_rf, s_cl, s_du;
  logic [NS-1:0] set_rf, set_cl, set_du;
  logic [CFGW-1:0] cfg;
  logic red_en, common_act, wd_lvl, drop, lgood, pnl, rem;
  logic rf_ok, chk_ok, ms, clr_short, clr_long, edge_wd;
  logic [10:0] rf_lim;
  logic [31:0] rd;
  logic hit;
  tcfm_flt_t set_f, clr_m;

  tcfm_tick #(
    .TICK_DIV(TICK_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .tm(tm.src)
  );
  tcfm_qual #(
    .N(2),
    .ON_CNT(`TCFM_INH_ON_CNT),
    .CW(10)
  ) u_inh (
    .sys_clk(sys_clk),
    .srst(srst),
    .tm(tm.snk),
    .raw(rf_inhibit),
    .qual(inh_q)
  );
  tcfm_qual #(
    .N(3 * NCH),
    .ON_CNT(`TCFM_IN_ON_CNT),
    .CW(10)
  ) u_field (
    .sys_clk(sys_clk),
    .srst(srst),
    .tm(tm.snk),
    .raw({grn_in, yel_in, red_in}),
    .qual(fq)
  );

  function automatic logic tcfm_multi(input logic [3:0] v);
    return (v & (v - 4'h1)) != 4'h0;
  endfunction : tcfm_multi

  always_comb begin
    ms = tm.ms_tick;
    {qg, qy, qr} = fq;
    red_en = st.s2[0];
    common_act = st.s2[1] ^ st.ctrl[`TCFM_C_POL];
    wd_lvl = st.s2[2];
    drop = st.s2[3];
    lgood = st.s2[4];
    pnl = st.s2[5];
    rem = st.s2[6];
    edge_wd = wd_lvl != st.wd_prev;
    cfg = {st.ctrl, st.rf_en, st.clr_en, st.dual_en, st.yinh};
    rf_ok = (st.state == TCFM_ST_RUN) && red_en && !(|inh_q) && !common_act;
    chk_ok = (st.state == TCFM_ST_RUN) && red_en && !common_act;
    rf_lim = st.ctrl[`TCFM_C_TYPE] ? 11'(`TCFM_RF_B_CNT) : 11'(`TCFM_RF_A_CNT);
    sr = {4'h0, qr};
    sy = {4'h0, qy};
    sg = {4'h0, qg};
    sga = '0;
    s_rf = {4'h0, st.rf_en};
    s_cl = {4'h0, st.clr_en & ~st.yinh};
    s_du = {4'h0, st.dual_en};
    for (int p = 0; p < 4; p++) begin
      if (st.ctrl[`TCFM_C_ARROW + p]) begin
        if (!st.ctrl[`TCFM_C_COMPACT]) begin
          sr[NCH+p] = qr[8+p];
          sy[NCH+p] = qy[8+p];
          sg[NCH+p] = qg[8+p];
          sga[NCH+p] = qg[2*p];
          s_rf[8+p] = 1'b0;
          s_cl[8+p] = 1'b0;
          s_du[8+p] = 1'b0;
        end else begin
          sr[NCH+p] = qr[2*p];
          sy[NCH+p] = qy[2*p];
          sg[NCH+p] = qg[2*p];
          sga[NCH+p] = p[0] ? qy[8+p/2] : qg[8+p/2];
          s_rf[2*p] = 1'b0;
          s_cl[2*p] = 1'b0;
          s_du[2*p] = 1'b0;
        end
        s_rf[NCH+p] = 1'b1;
        s_cl[NCH+p] = 1'b1;
        s_du[NCH+p] = 1'b1;
      end
    end
  end

  always_comb begin
    n = st;
    n.s1 = {remote_reset, panel_reset, line_ok, line_dropout, watchdog_in, relay_common_sense, red_enable};
    n.s2 = st.s1;
    n.wd_prev = wd_lvl;
    n.pnl_prev = pnl;
    n.rem_prev = rem;
    set_rf = '0;
    set_cl = '0;
    set_du = '0;
    set_f = '0;
    for (int i = 0; i < NS; i++) begin
      if (!(rf_ok && s_rf[i]) || sr[i] || sy[i] || sg[i] || sga[i]) begin
        n.acnt[i] = '0;
      end else if (ms) begin
        if (st.acnt[i] >= rf_lim) begin
          set_rf[i] = 1'b1;
        end else begin
          n.acnt[i] = st.acnt[i] + 11'h001;
        end
      end
      if (!chk_ok || !(s_du[i] ? tcfm_multi({sr[i], sy[i], sg[i], sga[i]})
          : (st.ctrl[`TCFM_C_GY_DUAL] && sg[i] && sy[i]))) begin
        n.dcnt[i] = '0;
      end else if (ms) begin
        if (st.dcnt[i] >= 9'(`TCFM_DUAL_CNT)) begin
          set_du[i] = 1'b1;
        end else begin
          n.dcnt[i] = st.dcnt[i] + 9'h001;
        end
      end
      if (!(chk_ok && s_cl[i])) begin
        n.gseen[i] = 1'b0;
        n.ycnt[i] = '0;
      end else if (sg[i] || sga[i]) begin
        n.gseen[i] = 1'b1;
        n.ycnt[i] = '0;
      end else if (st.gseen[i]) begin
        if (st.ycnt[i] >= 12'(`TCFM_CLR_CNT)) begin
          n.gseen[i] = 1'b0;
        end else if (sr[i]) begin
          // red arrived before a full yellow: missing or short
          set_cl[i] = 1'b1;
          n.gseen[i] = 1'b0;
        end else if (ms && sy[i]) begin
          n.ycnt[i] = st.ycnt[i] + 12'h001;
        end
      end
    end
    set_f[`TCFM_F_RED] = |set_rf;
    set_f[`TCFM_F_CLR] = |set_cl;
    set_f[`TCFM_F_DUAL] = |set_du;
    clr_long = pnl && ms && st.hold == 12'(`TCFM_CFG_RST_CNT - 1);
    n.snap_ok = 1'b1;
    if (!st.snap_ok) begin
      n.snap = cfg;
    // the long hold adopts the new settings, so the stale snapshot must not set again
    end else if (ms && cfg != st.snap && !clr_long) begin
      set_f[`TCFM_F_CFG] = 1'b1;
    end
    if (!pnl) begin
      n.hold = '0;
    end else if (ms && st.hold < 12'(`TCFM_CFG_RST_CNT)) begin
      n.hold = st.hold + 12'h001;
    end
    if (clr_long) begin
      n.snap = cfg;
    end
    clr_short = (pnl && !st.pnl_prev) || (rem && !st.rem_prev);
    clr_m = '0;
    clr_m[`TCFM_F_CFG] = clr_long;
    clr_m[`TCFM_F_RED] = clr_short;
    clr_m[`TCFM_F_CLR] = clr_short;
    clr_m[`TCFM_F_DUAL] = clr_short;
    clr_m[`TCFM_F_WDT] = clr_short;
    // start-up and line supervision
    unique case (st.state)
      TCFM_ST_START: begin
        if (ms && st.tcnt < 14'(`TCFM_ST_MAX_CNT)) begin
          n.tcnt = st.tcnt + 14'h0001;
        end
        if (edge_wd && st.wd_n < `TCFM_WD_EDGES) begin
          n.wd_n = st.wd_n + 3'h1;
        end
        if (drop) begin
          n.state = TCFM_ST_DROP;
        end else if (st.tcnt >= 14'(`TCFM_ST_MIN_CNT) && st.wd_n >= `TCFM_WD_EDGES && lgood) begin
          n.state = TCFM_ST_RUN;
        end else if (st.tcnt >= 14'(`TCFM_ST_MAX_CNT)) begin
          set_f[`TCFM_F_WDT] = 1'b1;
          n.state = TCFM_ST_RUN;
        end
      end
      TCFM_ST_RUN: begin
        if (drop) begin
          n.state = TCFM_ST_DROP;
        end
      end
      TCFM_ST_DROP: begin
        if (!drop && lgood) begin
          n.state = TCFM_ST_START;
          n.tcnt = '0;
          n.wd_n = '0;
        end
      end
    endcase
    n.flt = (st.flt & ~clr_m) | set_f;
    n.flt[`TCFM_F_PWR] = n.state == TCFM_ST_DROP;
    n.fch = (st.fch & ~{NS{clr_short}}) | set_rf | set_cl | set_du;
    n.relay = (n.flt != '0) || (n.state != TCFM_ST_RUN);
    unique case (n.state)
      TCFM_ST_START: n.pwr_led = tm.blink4;
      TCFM_ST_DROP: n.pwr_led = tm.blink2;
      default: n.pwr_led = 1'b1;
    endcase
    n.card_led = n.flt[`TCFM_F_CFG] && tm.blink2;
    // APB: one-cycle access phase, answer prepared in setup
    hit = 1'b1;
    rd = '0;
    case (paddr)
      `TCFM_A_CTRL: rd[7:0] = st.ctrl;
      `TCFM_A_RF_EN: rd[NCH-1:0] = st.rf_en;
      `TCFM_A_CLR_EN: rd[NCH-1:0] = st.clr_en;
      `TCFM_A_DUAL_EN: rd[NCH-1:0] = st.dual_en;
      `TCFM_A_YINH: rd[NCH-1:0] = st.yinh;
      `TCFM_A_STATUS: begin
        rd[5:0] = st.flt;
        rd[`TCFM_S_STATE+:2] = st.state;
        hit = !pwrite;
      end
      `TCFM_A_FAULT_CH: begin
        rd[NS-1:0] = st.fch;
        hit = !pwrite;
      end
      default: hit = 1'b0;
    endcase
    n.pready = psel && !penable && !st.pready;
    n.pslverr = psel && !penable && !st.pready && !hit;
    if (psel && !penable && !st.pready) begin
      n.prdata = hit ? rd : 32'h0000_0000;
    end
    if (psel && penable && st.pready && pwrite && !st.pslverr) begin
      case (paddr)
        `TCFM_A_CTRL: n.ctrl = pwdata[7:0];
        `TCFM_A_RF_EN: n.rf_en = pwdata[NCH-1:0];
        `TCFM_A_CLR_EN: n.clr_en = pwdata[NCH-1:0];
        `TCFM_A_DUAL_EN: n.dual_en = pwdata[NCH-1:0];
        `TCFM_A_YINH: n.yinh = pwdata[NCH-1:0];
        default: n.ctrl = st.ctrl;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.relay <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign relay_flash = st.relay;
  assign power_led = st.pwr_led;
  assign card_led = st.card_led;
  assign fault_flags = st.flt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_rf_inhibit: assert property (|inh_q |=> !$rose(st.flt[`TCFM_F_RED]))
    else $error("red failure set while inhibited");
  a_fault_latch: assert property (st.flt[`TCFM_F_DUAL] && !clr_short |=> st.flt[`TCFM_F_DUAL])
    else $error("dual fault dropped without reset");
  a_cfg_remote: assert property (st.flt[`TCFM_F_CFG] && !clr_long |=> st.flt[`TCFM_F_CFG])
    else $error("config fault cleared without long hold");
  a_startup_min: assert property (st.state == TCFM_ST_START ##1 st.state == TCFM_ST_RUN
    |-> $past(st.tcnt) >= 14'(`TCFM_ST_MIN_CNT))
    else $error("start-up ended too early");
  a_wdt_timeout: assert property (st.state == TCFM_ST_START && st.tcnt >= 14'(`TCFM_ST_MAX_CNT)
    && st.wd_n < `TCFM_WD_EDGES && !drop |=> st.flt[`TCFM_F_WDT])
    else $error("watchdog fault missing at timeout");
  a_relay_flash: assert property (st.state != TCFM_ST_RUN || st.flt != '0 |-> relay_flash)
    else $error("relay released while faulted or starting");
  a_power_blink: assert property (st.state == TCFM_ST_DROP |-> power_led == $past(tm.blink2))
    else $error("power led not at 2 Hz during dropout");
  a_checks_idle: assert property (st.state != TCFM_ST_RUN
    |=> !$rose(st.flt[`TCFM_F_CLR]) && !$rose(st.flt[`TCFM_F_DUAL]))
    else $error("check fired during start-up");
  a_apb_ready: assert property (psel && !penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  c_red_fail: cover property ($rose(st.flt[`TCFM_F_RED]));
  c_startup_done: cover property (st.state == TCFM_ST_START ##1 st.state == TCFM_ST_RUN);
  c_cfg_clear: cover property ($fell(st.flt[`TCFM_F_CFG]));
  c_dropout: cover property ($rose(st.flt[`TCFM_F_PWR]));
endmodule : tcfm_monitor
`default_nettype wire

// File: verification/tcfm_ctrl_model.sv
// partner model: signal controller watchdog output and cabinet field outputs
`timescale 1ns/1ps
`default_nettype none
module tcfm_ctrl_model #(
  parameter int WD_HALF = 400
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wd_run,
  input wire logic [17:0] red_cmd,
  input wire logic [17:0] yel_cmd,
  input wire logic [17:0] grn_cmd,
  output logic [17:0] red_out,
  output logic [17:0] yel_out,
  output logic [17:0] grn_out,
  output logic watchdog_out
);
  int cnt;
  // field loads follow the controller's commands one clock later
  always @(posedge sys_clk) begin
    red_out <= red_cmd;
    yel_out <= yel_cmd;
    grn_out <= grn_cmd;
    if (srst || !wd_run) begin
      cnt <= 0;
      if (srst) watchdog_out <= 1'b0;
    end else if (cnt == WD_HALF - 1) begin
      cnt <= 0;
      watchdog_out <= !watchdog_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tcfm_ctrl_model
`default_nettype wire

// File: verification/tcfm_monitor_tb.sv
// self-checking bench of the traffic conflict fault monitor
`timescale 1ns/1ps
`default_nettype none
`include "tcfm_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tcfm_monitor_tb;
  import tcfm_pkg::*;
  localparam int TD = 2;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, red_enable = 1'b1, watchdog_in, line_dropout = 1'b0, line_ok = 1'b1;
  logic panel_reset = 1'b0, remote_reset = 1'b0, relay_flash, power_led, card_led, wd_run = 1'b1, common = 1'b0;
  logic [1:0] rf_inhibit = 2'b00;
  logic [17:0] red_c = 18'h3_ffff, yel_c = 18'h0_0000, grn_c = 18'h0_0000, red_in, yel_in, grn_in;
  tcfm_flt_t fault_flags;
  int err_count = 0, n_checks = 0, cyc = 0, ch;
  always #20 sys_clk = ~sys_clk;
  tcfm_ctrl_model #(.WD_HALF(200 * TD)) tcfm_ctrl_model_inst (.sys_clk(sys_clk), .srst(srst),
    .wd_run(wd_run), .red_cmd(red_c), .yel_cmd(yel_c), .grn_cmd(grn_c), .red_out(red_in),
    .yel_out(yel_in), .grn_out(grn_in), .watchdog_out(watchdog_in));
  tcfm_monitor #(.NCH(18), .TICK_DIV(TD)) tcfm_monitor_inst (.sys_clk(sys_clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .red_in(red_in), .yel_in(yel_in),
    .grn_in(grn_in), .red_enable(red_enable), .rf_inhibit(rf_inhibit),
    .relay_common_sense(common), .watchdog_in(watchdog_in), .line_dropout(line_dropout),
    .line_ok(line_ok), .panel_reset(panel_reset), .remote_reset(remote_reset),
    .relay_flash(relay_flash), .power_led(power_led), .card_led(card_led), .fault_flags(fault_flags));
  function automatic tcfm_flt_t fbit(input int i);
    return tcfm_flt_t'(1) << i;
  endfunction : fbit
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // a hang is cut short well past the planned run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic wait_ms(input int n);
    repeat (n * TD) @(posedge sys_clk);
  endtask : wait_ms
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait-state count is assumed: only the bench timeout ends a wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic remote_pulse();
    @(posedge sys_clk) remote_reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    remote_reset <= 1'b0;
    wait_ms(2);
  endtask : remote_pulse
  initial begin
    void'($urandom(32'h9c28_9535));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    `CHK(relay_flash, 1'b1)
    apb(1'b0, `TCFM_A_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h1C, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, `TCFM_A_STATUS, 32'h0000_00ff);
    `CHK(er, 1'b1)
    wait_ms(5000);
    `CHK({relay_flash, fault_flags}, {1'b1, 6'h00})
    wait_ms(1100);
    apb(1'b0, `TCFM_A_STATUS, 32'h0000_0000);
    `CHK({relay_flash, power_led, rd[9:0]}, {2'b01, 10'h100})
    // every enable write counts as a config change, so one panel hold covers them all
    apb(1'b1, `TCFM_A_RF_EN, 32'h0003_ffff);
    apb(1'b1, `TCFM_A_DUAL_EN, 32'h0003_ffff);
    apb(1'b1, `TCFM_A_CLR_EN, 32'h0003_ffff);
    apb(1'b1, `TCFM_A_YINH, 32'h0000_0000);
    wait_ms(3);
    `CHK({relay_flash, fault_flags}, {1'b1, fbit(`TCFM_F_CFG)})
    // the card led blinks at 2 Hz, so it flips once in every 250 ms
    er = card_led;
    wait_ms(250);
    `CHK(card_led, ~er)
    remote_pulse();
    `CHK(fault_flags, fbit(`TCFM_F_CFG))
    @(posedge sys_clk) panel_reset <= 1'b1;
    wait_ms(1000);
    panel_reset <= 1'b0;
    wait_ms(3);
    `CHK(fault_flags, fbit(`TCFM_F_CFG))
    panel_reset <= 1'b1;
    wait_ms(3100);
    panel_reset <= 1'b0;
    wait_ms(3);
    `CHK({relay_flash, fault_flags}, {1'b0, 6'h00})
    ch = $urandom % 18;
    red_c[ch] <= 1'b0;
    wait_ms(700);
    `CHK(fault_flags, 6'h00)
    wait_ms(400);
    `CHK({relay_flash, fault_flags}, {1'b1, fbit(`TCFM_F_RED)})
    apb(1'b0, `TCFM_A_FAULT_CH, 32'h0000_0000);
    `CHK(rd[17:0], 18'h0_0001 << ch)
    red_c[ch] <= 1'b1;
    wait_ms(600);
    `CHK(fault_flags, fbit(`TCFM_F_RED))
    remote_pulse();
    `CHK(fault_flags, 6'h00)
    rf_inhibit <= 2'b01 << ($urandom % 2);
    wait_ms(600);
    red_c[ch] <= 1'b0;
    wait_ms(1200);
    `CHK(fault_flags, 6'h00)
    red_c[ch] <= 1'b1;
    wait_ms(600);
    rf_inhibit <= 2'b00;
    // an active relay common holds off red failure as well
    common <= 1'b1;
    red_c[ch] <= 1'b0;
    wait_ms(1200);
    `CHK(fault_flags, 6'h00)
    common <= 1'b0;
    red_c[ch] <= 1'b1;
    wait_ms(600);
    ch = $urandom % 18;
    yel_c[ch] <= 1'b1;
    wait_ms(150);
    yel_c[ch] <= 1'b0;
    wait_ms(600);
    `CHK(fault_flags, 6'h00)
    yel_c[ch] <= 1'b1;
    wait_ms(1100);
    `CHK(fault_flags, fbit(`TCFM_F_DUAL))
    yel_c[ch] <= 1'b0;
    remote_pulse();
    `CHK(fault_flags, 6'h00)
    ch = $urandom % 8;
    red_c[ch] <= 1'b0; grn_c[ch] <= 1'b1;
    wait_ms(800);
    grn_c[ch] <= 1'b0; yel_c[ch] <= 1'b1;
    wait_ms(1000);
    yel_c[ch] <= 1'b0; red_c[ch] <= 1'b1;
    wait_ms(700);
    `CHK(fault_flags, fbit(`TCFM_F_CLR))
    remote_pulse();
    // second controller type, inverted common polarity, phase 1 standard arrow
    common <= 1'b1;
    apb(1'b1, `TCFM_A_CTRL, 32'h0000_0019);
    panel_reset <= 1'b1;
    wait_ms(3100);
    panel_reset <= 1'b0;
    wait_ms(3);
    `CHK(fault_flags, 6'h00)
    red_c[8] <= 1'b0;
    wait_ms(1150);
    `CHK(fault_flags, 6'h00)
    wait_ms(500);
    `CHK(fault_flags, fbit(`TCFM_F_RED))
    apb(1'b0, `TCFM_A_FAULT_CH, 32'h0000_0000);
    `CHK(rd[21:0], 22'h04_0000)
    red_c[8] <= 1'b1;
    wait_ms(600);
    remote_pulse();
    `CHK(fault_flags, 6'h00)
    line_dropout <= 1'b1; line_ok <= 1'b0;
    wait_ms(10);
    `CHK({relay_flash, fault_flags}, {1'b1, fbit(`TCFM_F_PWR)})
    line_dropout <= 1'b0; line_ok <= 1'b1;
    wait_ms(10);
    apb(1'b0, `TCFM_A_STATUS, 32'h0000_0000);
    `CHK({relay_flash, rd[9:0]}, {1'b1, 10'h000})
    // third start-up with a silent controller must latch the watchdog fault
    wd_run <= 1'b0; srst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    wait_ms(9000);
    `CHK(fault_flags, 6'h00)
    wait_ms(1100);
    `CHK({relay_flash, fault_flags}, {1'b1, fbit(`TCFM_F_WDT)})
    end_sim();
  end
endmodule : tcfm_monitor_tb
`default_nettype wire
